//--- dv/asl_line_partner.sv
// Modem side model: serial frames at divisor 1 and modem status levels
`timescale 1ns/1ps
module asl_line_partner (
    input  wire logic           clk_sys,
    input  wire logic           serial_out,
    output logic                serial_in,
    output asl_pkg::asl_modem_t modem_in
);
    initial
    begin
        serial_in = 1'b1;
        modem_in = 4'h0;
    end

    // Send n bits lsb first, 16 clocks each, then idle mark
    task automatic tx_frame(input logic [11:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_sys);
            serial_in = b[i];
            repeat (15) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        serial_in = 1'b1;
        repeat (16) @(negedge clk_sys);
    endtask : tx_frame

    // Catch a frame from its start edge, sampling mid-bit
    task automatic rx_frame(input int n, output logic [11:0] b);
        int k;
        k = 0;
        b = 12'h000;
        while (serial_out !== 1'b0 && k < 2000)
        begin
            @(negedge clk_sys);
            k++;
        end
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            b[i] = serial_out;
            repeat (16) @(negedge clk_sys);
        end
    endtask : rx_frame

    task automatic set_modem(input logic [3:0] m);
        @(negedge clk_sys);
        modem_in = m;
    endtask : set_modem
endmodule : asl_line_partner

//--- dv/asl_serial_line_monitor.sv
// Port checker for the serial line element
`timescale 1ns/1ps
module asl_serial_line_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       host_rd,
    input wire logic       host_wr,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic       serial_out,
    input wire logic       dtr_out,
    input wire logic       rts_out,
    input wire logic       user_out1,
    input wire logic       user_out2
);
    // ----------------------------------------
    // Shadow of loop and break bits
    // ----------------------------------------
    logic lp_q, lp2_q, brk_q, brk2_q;
    wire  mw = host_wr && host_addr == 3'h4;
    wire  lw = host_wr && host_addr == 3'h3;
    wire  sr = host_rd && host_addr == 3'h5;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            {lp_q, lp2_q, brk_q, brk2_q} <= 4'h0;
        else
        begin
            lp_q <= mw ? host_wdata[4] : lp_q;
            brk_q <= lw ? host_wdata[6] : brk_q;
            {lp2_q, brk2_q} <= {lp_q, brk_q};
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    dtr_pin_a: assert property (mw |=> ##1 dtr_out == $past(host_wdata[0], 2))
        else $error("terminal ready pin wrong");
    rts_pin_a: assert property (mw |=> ##1 rts_out == $past(host_wdata[1], 2))
        else $error("request to send pin wrong");
    user_one_a: assert property (mw |=> ##1 user_out1 == $past(host_wdata[2], 2))
        else $error("user output one wrong");
    user_two_a: assert property (mw |=> ##1 user_out2 == $past(host_wdata[3], 2))
        else $error("user output two wrong");
    loop_idle_a: assert property (lp_q && lp2_q |-> serial_out)
        else $error("serial output not idle in loopback");
    break_low_a: assert property (brk_q && brk2_q && !lp_q && !lp2_q |-> !serial_out)
        else $error("serial output not spacing during break");
    stat_top_a: assert property (sr |=> !host_rdata[7])
        else $error("line status bit 7 set");
    empty_order_a: assert property (sr |=> !host_rdata[6] || host_rdata[5])
        else $error("shifter empty while holding full");
    err_clear_a: assert property (sr ##2 sr |=> host_rdata[4:1] == 4'h0)
        else $error("error flags survive status read");
    cfg_back_a: assert property (lw ##2 (host_rd && host_addr == 3'h3)
        |=> host_rdata == $past(host_wdata, 3))
        else $error("line config readback wrong");

    cover property (lp_q && lp2_q);
    cover property (brk_q && brk2_q);
    cover property (sr ##1 host_rdata[0]);
endmodule : asl_serial_line_monitor

bind asl_serial_line asl_serial_line_monitor u_mon (.clk_sys, .rst, .host_rd, .host_wr,
    .host_addr, .host_wdata, .host_rdata, .serial_out, .dtr_out, .rts_out, .user_out1,
    .user_out2);

//--- dv/tb.sv
// Register level testbench of the serial line element
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0, rst = 1'b1, host_rd = 1'b0, host_wr = 1'b0;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] host_wdata = 8'h00, host_rdata, d;
    logic serial_in, serial_out, dtr_out, rts_out, user_out1, user_out2;
    logic [11:0] f;
    asl_pkg::asl_modem_t modem_in;
    int error_cnt = 0, tests_run = 0, cyc = 0, k = 0;
    logic [7:0] cfgs [4] = '{8'h00, 8'h0D, 8'h12, 8'h1F};

    asl_serial_line dut (.clk_sys, .rst, .host_rd, .host_wr, .host_addr, .host_wdata,
        .host_rdata, .serial_in, .serial_out, .modem_in, .dtr_out, .rts_out, .user_out1,
        .user_out2);
    asl_line_partner pm (.clk_sys, .serial_out, .serial_in, .modem_in);

    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        {host_wr, host_addr, host_wdata} = {1'b1, a, v};
        @(negedge clk_sys);
        host_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        {host_rd, host_addr} = {1'b1, a};
        @(negedge clk_sys);
        host_rd = 1'b0;
        v = host_rdata;
    endtask : rd

    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rc

    task automatic wait_lsr(input logic [7:0] m);
        int k;
        k = 0;
        d = 8'h00;
        while ((d & m) !== m && k < 600)
        begin
            rd(3'h5, d);
            k++;
        end
        chk(d & m, m);
    endtask : wait_lsr

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        rc(3'h3, 8'h00);
        rc(3'h4, 8'h00);
        rc(3'h5, 8'h60);
        rc(3'h6, 8'h00);
        wr(3'h3, 8'h80);
        rc(3'h0, 8'h0C);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        rc(3'h0, 8'h01);
        rc(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        rc(3'h3, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h4, 8'h01 << i);
            repeat (3) @(negedge clk_sys);
            chk({user_out2, user_out1, rts_out, dtr_out}, 4'h1 << i);
        end
        wr(3'h4, 8'h1F);
        repeat (6) @(negedge clk_sys);
        rc(3'h6, 8'hFB);
        wr(3'h4, 8'h13);
        repeat (6) @(negedge clk_sys);
        rc(3'h6, 8'h3C);
        for (int c = 0; c < 4; c++)
        begin
            wr(3'h3, cfgs[c]);
            wr(3'h0, 8'hA5);
            chk(serial_out, 1'b1);
            wait_lsr(8'h01);
            rc(3'h0, 8'hA5 & (8'hFF >> (3 - c)));
            wait_lsr(8'h40);
            chk(d, 8'h60);
        end
        wr(3'h3, 8'h03);
        wr(3'h0, 8'h11);
        wait_lsr(8'h01);
        wr(3'h0, 8'h22);
        repeat (250) @(negedge clk_sys);
        rc(3'h5, 8'h63);
        rc(3'h0, 8'h22);
        wr(3'h4, 8'h03);
        repeat (6) @(negedge clk_sys);
        rd(3'h6, d);
        wr(3'h3, 8'h1B);
        wr(3'h0, 8'h96);
        pm.rx_frame(11, f);
        chk(f, 12'h52C);
        wr(3'h3, 8'h0B);
        wr(3'h0, 8'h96);
        pm.rx_frame(11, f);
        chk(f, 12'h72C);
        wr(3'h3, 8'h3B);
        wr(3'h0, 8'h97);
        pm.rx_frame(11, f);
        chk(f, 12'h52E);
        wr(3'h3, 8'h1B);
        pm.tx_frame(12'h478, 11);
        rc(3'h5, 8'h61);
        rc(3'h0, 8'h3C);
        pm.tx_frame(12'h678, 11);
        rc(3'h5, 8'h65);
        rc(3'h5, 8'h61);
        rd(3'h0, d);
        pm.tx_frame(12'h078, 11);
        rc(3'h5, 8'h69);
        rd(3'h0, d);
        pm.tx_frame(12'h000, 12);
        rd(3'h5, d);
        chk(d & 8'h10, 8'h10);
        rd(3'h5, d);
        chk(d & 8'h1E, 8'h00);
        rd(3'h0, d);
        pm.set_modem(4'b1000);
        repeat (6) @(negedge clk_sys);
        rc(3'h6, 8'h11);
        pm.set_modem(4'b0110);
        repeat (6) @(negedge clk_sys);
        rc(3'h6, 8'h63);
        pm.set_modem(4'b0001);
        repeat (6) @(negedge clk_sys);
        rc(3'h6, 8'h8E);
        rc(3'h6, 8'h80);
        wr(3'h3, 8'h04);
        wr(3'h0, 8'h00);
        wr(3'h0, 8'h00);
        while (serial_out !== 1'b0)
            @(negedge clk_sys);
        while (serial_out === 1'b0)
            @(negedge clk_sys);
        while (serial_out === 1'b1 && k < 40)
        begin
            @(negedge clk_sys);
            k++;
        end
        chk(k >= 24 && k < 32, 1'b1);
        wait_lsr(8'h40);
        wr(3'h3, 8'h43);
        repeat (3) @(negedge clk_sys);
        chk(serial_out, 1'b0);
        wr(3'h3, 8'h03);
        repeat (3) @(negedge clk_sys);
        chk(serial_out, 1'b1);
        close_out();
    end
endmodule : tb

//--- rtl/asl_params.svh
// Offsets, field positions, reset values and timing counts of the serial line block
`ifndef ASL_PARAMS_SVH
`define ASL_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASL_OFF_DATA    3'h0
`define ASL_OFF_IEN     3'h1
`define ASL_OFF_IID     3'h2
`define ASL_OFF_LCFG    3'h3
`define ASL_OFF_MCTL    3'h4
`define ASL_OFF_LSTAT   3'h5
`define ASL_OFF_MSTAT   3'h6
`define ASL_OFF_SCR     3'h7

// ----------------------------------------
// Line configuration fields
// ----------------------------------------
`define ASL_LC_MULTI_STOP 2
`define ASL_LC_PAR_EN     3
`define ASL_LC_PAR_EVEN   4
`define ASL_LC_PAR_STICK  5
`define ASL_LC_BREAK      6
`define ASL_LC_DLAB       7

// ----------------------------------------
// Modem control fields
// ----------------------------------------
`define ASL_MC_DTR   0
`define ASL_MC_RTS   1
`define ASL_MC_OUT1  2
`define ASL_MC_OUT2  3
`define ASL_MC_LOOP  4

// ----------------------------------------
// Reset values and fixed read values
// ----------------------------------------
`define ASL_LCFG_RST  8'h00
`define ASL_MCTL_RST  8'h00
`define ASL_DIV_RST   16'h000C
`define ASL_IID_VAL   8'h01

// ----------------------------------------
// Timing in 16x ticks
// ----------------------------------------
`define ASL_BIT_LAST   4'hF
`define ASL_MID_BIT    4'h7
`define ASL_STOP_ONE   6'h10
`define ASL_STOP_HALF  6'h18
`define ASL_STOP_TWO   6'h20

`endif

//--- rtl/asl_pkg.sv
// Types of the serial line block
package asl_pkg;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h2,
        TX_PAR   = 3'h3,
        TX_STOP  = 3'h4
    } asl_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h2,
        RX_PAR   = 3'h3,
        RX_STOP  = 3'h4,
        RX_BRK   = 3'h5
    } asl_rx_st_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
    } asl_modem_t;

    typedef struct packed {
        logic [7:0]  lcfg;
        logic [7:0]  mctl;
        logic [7:0]  scr;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic [7:0]  rdata;
        logic [7:0]  thr;
        logic        thr_empty;
        asl_tx_st_t  tx_st;
        logic [7:0]  tx_sh;
        logic [5:0]  tx_sub;
        logic [2:0]  tx_bit;
        logic        tx_par;
        asl_rx_st_t  rx_st;
        logic [3:0]  rx_sub;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        rx_par;
        logic        rx_zero;
        logic [7:0]  rbr;
        logic        dr;
        logic        oe;
        logic        pe;
        logic        fe;
        logic        bi;
        logic        rx_s1;
        logic        rx_s2;
        asl_modem_t  m_s1;
        asl_modem_t  m_s2;
        asl_modem_t  m_prev;
        logic [3:0]  dmsr;
        logic        txd;
        logic        dtr;
        logic        rts;
        logic        out1;
        logic        out2;
    } asl_state_t;

endpackage : asl_pkg

//--- rtl/asl_serial_line.sv
// Serial line element: framing, modem control, line and modem status, baud divisor
`timescale 1ns/1ps
`include "asl_params.svh"

module asl_serial_line (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              host_rd,
    input  wire logic              host_wr,
    input  wire logic [2:0]        host_addr,
    input  wire logic [7:0]        host_wdata,
    output logic      [7:0]        host_rdata,
    input  wire logic              serial_in,
    output logic                   serial_out,
    input  wire asl_pkg::asl_modem_t modem_in,
    output logic                   dtr_out,
    output logic                   rts_out,
    output logic                   user_out1,
    output logic                   user_out2
);

    asl_pkg::asl_state_t q;
    asl_pkg::asl_state_t d;

    logic                tick;
    logic                dlab;
    logic                loop;
    logic [2:0]          last_bit;
    logic [5:0]          stop_len;
    logic                tx_line;
    logic                rx_line;
    logic                par_exp;
    asl_pkg::asl_modem_t m_now;
    logic [7:0]          lstat;
    logic [7:0]          mstat;

    // ----------------------------------------
    // Derived configuration
    // ----------------------------------------
    always_comb
    begin
        dlab     = q.lcfg[`ASL_LC_DLAB];
        loop     = q.mctl[`ASL_MC_LOOP];
        last_bit = 3'(q.lcfg[1:0] + 3'h4);
        if (!q.lcfg[`ASL_LC_MULTI_STOP])
            stop_len = `ASL_STOP_ONE;
        else if (q.lcfg[1:0] == 2'h0)
            stop_len = `ASL_STOP_HALF;
        else
            stop_len = `ASL_STOP_TWO;
        tick = (q.bcnt == 16'(q.div - 16'h0001));
    end

    // ----------------------------------------
    // Line levels and status views
    // ----------------------------------------
    always_comb
    begin
        if (q.lcfg[`ASL_LC_PAR_STICK])
            par_exp = ~q.lcfg[`ASL_LC_PAR_EVEN];
        else
            par_exp = q.lcfg[`ASL_LC_PAR_EVEN] ? q.tx_par : ~q.tx_par;
        case (q.tx_st)
            asl_pkg::TX_START: tx_line = 1'b0;
            asl_pkg::TX_DATA:  tx_line = q.tx_sh[0];
            asl_pkg::TX_PAR:   tx_line = par_exp;
            default:           tx_line = 1'b1;
        endcase
        if (loop)
        begin
            rx_line = tx_line & ~q.lcfg[`ASL_LC_BREAK];
            m_now.cts = q.mctl[`ASL_MC_RTS];
            m_now.dsr = q.mctl[`ASL_MC_DTR];
            m_now.ri  = q.mctl[`ASL_MC_OUT1];
            m_now.dcd = q.mctl[`ASL_MC_OUT2];
        end
        else
        begin
            rx_line = q.rx_s2;
            m_now   = q.m_s2;
        end
        lstat = {1'b0,
                 q.thr_empty && (q.tx_st == asl_pkg::TX_IDLE),
                 q.thr_empty,
                 q.bi, q.fe, q.pe, q.oe, q.dr};
        mstat = {m_now.dcd, m_now.ri, m_now.dsr, m_now.cts, q.dmsr};
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic rx_exp;
        rx_exp = 1'b0;
        d = q;
        // Input synchronisers
        d.rx_s1  = serial_in;
        d.rx_s2  = q.rx_s1;
        d.m_s1   = modem_in;
        d.m_s2   = q.m_s1;
        d.m_prev = m_now;
        // Baud divider
        d.bcnt = tick ? 16'h0000 : 16'(q.bcnt + 16'h0001);
        // Register reads with their side effects
        if (host_rd)
        begin
            case (host_addr)
                `ASL_OFF_DATA:
                    if (dlab)
                        d.rdata = q.div[7:0];
                    else
                    begin
                        d.rdata = q.rbr;
                        d.dr    = 1'b0;
                    end
                `ASL_OFF_IEN:  d.rdata = dlab ? q.div[15:8] : 8'h00;
                `ASL_OFF_IID:  d.rdata = `ASL_IID_VAL;
                `ASL_OFF_LCFG: d.rdata = q.lcfg;
                `ASL_OFF_MCTL: d.rdata = q.mctl;
                `ASL_OFF_LSTAT:
                begin
                    d.rdata = lstat;
                    d.oe    = 1'b0;
                    d.pe    = 1'b0;
                    d.fe    = 1'b0;
                    d.bi    = 1'b0;
                end
                `ASL_OFF_MSTAT:
                begin
                    d.rdata = mstat;
                    d.dmsr  = 4'h0;
                end
                default:       d.rdata = q.scr;
            endcase
        end
        // Modem change detection, set wins over the read clear
        if (m_now.cts != q.m_prev.cts)
            d.dmsr[0] = 1'b1;
        if (m_now.dsr != q.m_prev.dsr)
            d.dmsr[1] = 1'b1;
        if (q.m_prev.ri && !m_now.ri)
            d.dmsr[2] = 1'b1;
        if (m_now.dcd != q.m_prev.dcd)
            d.dmsr[3] = 1'b1;
        // Transmitter, one step per 16x tick
        if (tick)
        begin
            case (q.tx_st)
                asl_pkg::TX_IDLE:
                begin
                    if (!q.thr_empty)
                    begin
                        d.tx_sh     = q.thr;
                        d.thr_empty = 1'b1;
                        d.tx_st     = asl_pkg::TX_START;
                        d.tx_sub    = 6'h00;
                    end
                end
                asl_pkg::TX_START:
                begin
                    d.tx_sub = 6'(q.tx_sub + 6'h01);
                    if (q.tx_sub[3:0] == `ASL_BIT_LAST)
                    begin
                        d.tx_sub = 6'h00;
                        d.tx_bit = 3'h0;
                        d.tx_par = 1'b0;
                        d.tx_st  = asl_pkg::TX_DATA;
                    end
                end
                asl_pkg::TX_DATA:
                begin
                    d.tx_sub = 6'(q.tx_sub + 6'h01);
                    if (q.tx_sub[3:0] == `ASL_BIT_LAST)
                    begin
                        d.tx_sub = 6'h00;
                        d.tx_par = q.tx_par ^ q.tx_sh[0];
                        d.tx_sh  = {1'b0, q.tx_sh[7:1]};
                        d.tx_bit = 3'(q.tx_bit + 3'h1);
                        if (q.tx_bit == last_bit)
                            d.tx_st = q.lcfg[`ASL_LC_PAR_EN] ?
                                      asl_pkg::TX_PAR : asl_pkg::TX_STOP;
                    end
                end
                asl_pkg::TX_PAR:
                begin
                    d.tx_sub = 6'(q.tx_sub + 6'h01);
                    if (q.tx_sub[3:0] == `ASL_BIT_LAST)
                    begin
                        d.tx_sub = 6'h00;
                        d.tx_st  = asl_pkg::TX_STOP;
                    end
                end
                asl_pkg::TX_STOP:
                begin
                    d.tx_sub = 6'(q.tx_sub + 6'h01);
                    if (q.tx_sub == 6'(stop_len - 6'h01))
                    begin
                        d.tx_sub = 6'h00;
                        d.tx_st  = asl_pkg::TX_IDLE;
                    end
                end
                default: d.tx_st = asl_pkg::TX_IDLE;
            endcase
        end
        // Receiver, sampling on the 16x tick
        if (tick)
        begin
            case (q.rx_st)
                asl_pkg::RX_IDLE:
                begin
                    if (!rx_line)
                    begin
                        d.rx_sub = 4'h0;
                        d.rx_st  = asl_pkg::RX_START;
                    end
                end
                asl_pkg::RX_START:
                begin
                    d.rx_sub = 4'(q.rx_sub + 4'h1);
                    if (q.rx_sub == `ASL_MID_BIT)
                    begin
                        d.rx_sub  = 4'h0;
                        d.rx_bit  = 3'h0;
                        d.rx_sh   = 8'h00;
                        d.rx_par  = 1'b0;
                        d.rx_zero = 1'b1;
                        d.rx_st   = rx_line ? asl_pkg::RX_IDLE : asl_pkg::RX_DATA;
                    end
                end
                asl_pkg::RX_DATA:
                begin
                    d.rx_sub = 4'(q.rx_sub + 4'h1);
                    if (q.rx_sub == `ASL_BIT_LAST)
                    begin
                        d.rx_sh[q.rx_bit] = rx_line;
                        d.rx_par  = q.rx_par ^ rx_line;
                        d.rx_zero = q.rx_zero & ~rx_line;
                        d.rx_bit  = 3'(q.rx_bit + 3'h1);
                        if (q.rx_bit == last_bit)
                            d.rx_st = q.lcfg[`ASL_LC_PAR_EN] ?
                                      asl_pkg::RX_PAR : asl_pkg::RX_STOP;
                    end
                end
                asl_pkg::RX_PAR:
                begin
                    d.rx_sub = 4'(q.rx_sub + 4'h1);
                    if (q.rx_sub == `ASL_BIT_LAST)
                    begin
                        if (q.lcfg[`ASL_LC_PAR_STICK])
                            rx_exp = ~q.lcfg[`ASL_LC_PAR_EVEN];
                        else
                            rx_exp = q.lcfg[`ASL_LC_PAR_EVEN] ? q.rx_par : ~q.rx_par;
                        d.rx_par  = (rx_line != rx_exp);
                        d.rx_zero = q.rx_zero & ~rx_line;
                        d.rx_st   = asl_pkg::RX_STOP;
                    end
                end
                asl_pkg::RX_STOP:
                begin
                    d.rx_sub = 4'(q.rx_sub + 4'h1);
                    if (q.rx_sub == `ASL_BIT_LAST)
                    begin
                        d.rbr = q.rx_sh;
                        d.dr  = 1'b1;
                        if (q.dr && !(host_rd && !dlab && host_addr == `ASL_OFF_DATA))
                            d.oe = 1'b1;
                        if (q.lcfg[`ASL_LC_PAR_EN] && q.rx_par)
                            d.pe = 1'b1;
                        if (!rx_line)
                            d.fe = 1'b1;
                        if (!rx_line && q.rx_zero)
                            d.bi = 1'b1;
                        d.rx_st = rx_line ? asl_pkg::RX_IDLE : asl_pkg::RX_BRK;
                    end
                end
                asl_pkg::RX_BRK: if (rx_line) d.rx_st = asl_pkg::RX_IDLE;
                default: d.rx_st = asl_pkg::RX_IDLE;
            endcase
        end
        // Register writes
        if (host_wr)
        begin
            case (host_addr)
                `ASL_OFF_DATA:
                    if (dlab)
                    begin
                        d.div[7:0] = host_wdata;
                        d.bcnt     = 16'h0000;
                    end
                    else
                    begin
                        d.thr       = host_wdata;
                        d.thr_empty = 1'b0;
                    end
                `ASL_OFF_IEN:
                    if (dlab)
                    begin
                        d.div[15:8] = host_wdata;
                        d.bcnt      = 16'h0000;
                    end
                `ASL_OFF_LCFG: d.lcfg = host_wdata;
                `ASL_OFF_MCTL: d.mctl = host_wdata;
                `ASL_OFF_SCR:  d.scr  = host_wdata;
                default:       d.scr  = q.scr;
            endcase
        end
        // Pin outputs
        d.txd  = loop ? 1'b1 :
                 (q.lcfg[`ASL_LC_BREAK] ? 1'b0 : tx_line);
        d.dtr  = q.mctl[`ASL_MC_DTR];
        d.rts  = q.mctl[`ASL_MC_RTS];
        d.out1 = q.mctl[`ASL_MC_OUT1];
        d.out2 = q.mctl[`ASL_MC_OUT2];
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q           <= '0;
            q.lcfg      <= `ASL_LCFG_RST;
            q.mctl      <= `ASL_MCTL_RST;
            q.div       <= `ASL_DIV_RST;
            q.thr_empty <= 1'b1;
            q.rx_s1     <= 1'b1;
            q.rx_s2     <= 1'b1;
            q.txd       <= 1'b1;
        end
        else
            q <= d;
    end

    assign host_rdata = q.rdata;
    assign serial_out = q.txd;
    assign dtr_out    = q.dtr;
    assign rts_out    = q.rts;
    assign user_out1  = q.out1;
    assign user_out2  = q.out2;

endmodule : asl_serial_line
